//--- design/sps_top.sv
`timescale 1ns/1ps
// Summary of operation
// - state moves only on step falling edge
// - direction picks forward or backward move
// - low select half steps, high full
// - disable floats phases and position flags
// - state advances while disabled, shows later
// - boost drives only while one-shot runs
// - up/down counter decoded to outputs
// - four bits A1 A2 B1 B2, 0 on
// - reset enters state 1010
// - reset state drives both flags low
// - 0110 forward full goes 0101, boost B
// - full mode jumps to next full state
// - no boost entering half-step states
// - eight states, four half, four full
// - boost fires when phase newly on
// - two open-collector half-step position flags
// - one shared on time for both one-shots
module sps_top
  import sps_pkg::*;
#(
  parameter int unsigned ON_CYCLES = sps_pkg::ONESHOT_CYC
)
(
  input  wire logic i_clk,
  input  wire logic i_rst,
  input  wire logic i_step,
  input  wire logic i_direction,
  input  wire logic i_half_step_select,
  input  wire logic i_output_disable,
  output logic      o_phase_a_first,
  output logic      o_phase_a_first_oe,
  output logic      o_phase_a_second,
  output logic      o_phase_a_second_oe,
  output logic      o_phase_b_first,
  output logic      o_phase_b_first_oe,
  output logic      o_phase_b_second,
  output logic      o_phase_b_second_oe,
  output logic      o_flag_a,
  output logic      o_flag_a_oe,
  output logic      o_flag_b,
  output logic      o_flag_b_oe,
  output logic      o_boost_a,
  output logic      o_boost_a_oe,
  output logic      o_boost_b,
  output logic      o_boost_b_oe
);
  import sps_pkg::*;

  localparam logic [ONESHOT_W-1:0] ON_CNT = ON_CYCLES[ONESHOT_W-1:0];

  logic              step_d_r;
  logic              step_d_nxt;
  logic [POS_W-1:0]  pos_r;
  logic [POS_W-1:0]  pos_nxt;
  logic              fall;
  logic [3:0]        code_now;
  logic [3:0]        code_new;
  logic              trig_a;
  logic              trig_b;
  logic              act_a;
  logic              act_b;
  logic [3:0]        code_r;
  logic [3:0]        code_nxt;
  logic [1:0]        flag_r;
  logic [1:0]        flag_nxt;
  logic              dis_r;

  // eight positions: full 1010,0110,0101,1001; halves between
  function automatic logic [3:0] decode(input logic [POS_W-1:0] p);
    logic [3:0] c;
    c = CODE_RESET;
    case (p)
      3'h0: c = 4'h000a;
      3'h1: c = 4'h000e;
      3'h2: c = 4'h0006;
      3'h3: c = 4'h0007;
      3'h4: c = 4'h0005;
      3'h5: c = 4'h000d;
      3'h6: c = 4'h0009;
      3'h7: c = 4'h000b;
      default: c = CODE_RESET;
    endcase
    return c;
  endfunction

  assign fall     = step_d_r & ~i_step;
  assign code_now = decode(pos_r);
  assign code_new = decode(pos_nxt);

  always_comb
  begin
    step_d_nxt = i_step;
    pos_nxt    = pos_r;
    if (fall)
    begin
      if (i_half_step_select)
      begin
        if (i_direction)
        begin
          pos_nxt = pos_r[0] ? pos_r + 3'h1 : pos_r + 3'h2;
        end
        else
        begin
          pos_nxt = pos_r[0] ? pos_r - 3'h1 : pos_r - 3'h2;
        end
      end
      else if (i_direction)
      begin
        pos_nxt = pos_r + 3'h1;
      end
      else
      begin
        pos_nxt = pos_r - 3'h1;
      end
    end
  end

  // boost on winding newly on entering full state
  always_comb
  begin
    trig_a = 1'b0;
    trig_b = 1'b0;
    if (fall && !pos_nxt[0])
    begin
      trig_a = (code_now[BIT_A1] & ~code_new[BIT_A1])
             | (code_now[BIT_A2] & ~code_new[BIT_A2]);
      trig_b = (code_now[BIT_B1] & ~code_new[BIT_B1])
             | (code_now[BIT_B2] & ~code_new[BIT_B2]);
    end
  end

  // registered outputs; flags low in full states
  always_comb
  begin
    code_nxt = code_new;
    flag_nxt = 2'h0;
    if (pos_nxt[0])
    begin
      flag_nxt = {pos_nxt[2], pos_nxt[1]};
      if (pos_nxt[2:1] == 2'h0)
      begin
        flag_nxt = 2'h3;
      end
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      step_d_r <= 1'b0;
      pos_r    <= POS_RESET;
      code_r   <= CODE_RESET;
      flag_r   <= 2'h0;
      dis_r    <= 1'b1;
    end
    else
    begin
      step_d_r <= step_d_nxt;
      pos_r    <= pos_nxt;
      code_r   <= code_nxt;
      flag_r   <= flag_nxt;
      dis_r    <= i_output_disable;
    end
  end

  // shared on time, each shot restarts only itself
  sps_oneshot #(.CNT_W(ONESHOT_W)) u_shot_a
  (
    .i_clk       (i_clk),
    .i_rst       (i_rst),
    .i_trig      (trig_a),
    .i_on_cycles (ON_CNT),
    .o_active    (act_a)
  );

  sps_oneshot #(.CNT_W(ONESHOT_W)) u_shot_b
  (
    .i_clk       (i_clk),
    .i_rst       (i_rst),
    .i_trig      (trig_b),
    .i_on_cycles (ON_CNT),
    .o_active    (act_b)
  );

  // open drain: pull low when bit is 0 and enabled; boosts drive high while their one-shot runs
  assign o_phase_a_first     = 1'b0;
  assign o_phase_a_second    = 1'b0;
  assign o_phase_b_first     = 1'b0;
  assign o_phase_b_second    = 1'b0;
  assign o_phase_a_first_oe  = ~dis_r & ~code_r[BIT_A1];
  assign o_phase_a_second_oe = ~dis_r & ~code_r[BIT_A2];
  assign o_phase_b_first_oe  = ~dis_r & ~code_r[BIT_B1];
  assign o_phase_b_second_oe = ~dis_r & ~code_r[BIT_B2];
  assign o_flag_a            = 1'b0;
  assign o_flag_b            = 1'b0;
  assign o_flag_a_oe         = ~dis_r & ~flag_r[1];
  assign o_flag_b_oe         = ~dis_r & ~flag_r[0];
  assign o_boost_a           = 1'b1;
  assign o_boost_b           = 1'b1;
  assign o_boost_a_oe        = act_a;
  assign o_boost_b_oe        = act_b;
endmodule

//--- pkg/sps_pkg.sv
package sps_pkg;
  localparam int unsigned CLK_HZ          = 200_000_000;
  localparam int unsigned STATE_W         = 4;
  localparam int unsigned POS_W           = 3;
  // position index: even = full-step state, odd = half-step state
  localparam logic [2:0]  POS_RESET       = 3'h0;
  localparam logic [3:0]  CODE_RESET      = 4'h0a;
  // bit positions in the phase code, A1 at msb
  localparam int unsigned BIT_A1          = 3;
  localparam int unsigned BIT_A2          = 2;
  localparam int unsigned BIT_B1          = 1;
  localparam int unsigned BIT_B2          = 0;
  // one-shot on time, default in microseconds
  localparam int unsigned ONESHOT_US      = 325;
  localparam int unsigned ONESHOT_CYC     = ONESHOT_US * (CLK_HZ / 1_000_000);
  localparam int unsigned ONESHOT_W       = 20;
endpackage

//--- design/sps_oneshot.sv
`timescale 1ns/1ps
module sps_oneshot
  import sps_pkg::*;
#(
  parameter int unsigned CNT_W = sps_pkg::ONESHOT_W
)
(
  input  wire logic             i_clk,
  input  wire logic             i_rst,
  input  wire logic             i_trig,
  input  wire logic [CNT_W-1:0] i_on_cycles,
  output logic                  o_active
);
  import sps_pkg::*;

  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;

  always_comb
  begin
    cnt_nxt = cnt_r;
    if (i_trig)
    begin
      cnt_nxt = i_on_cycles;
    end
    else if (cnt_r != '0)
    begin
      cnt_nxt = cnt_r - 1'b1;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      cnt_r <= '0;
    end
    else
    begin
      cnt_r <= cnt_nxt;
    end
  end

  assign o_active = (cnt_r != '0);
endmodule

//--- test/sps_winding_model.sv
`timescale 1ns/1ps
module sps_winding_model
(
  input  wire logic [3:0] i_phase_oe,
  input  wire logic [1:0] i_flag_oe,
  output logic      [3:0] o_phase_pin,
  output logic      [1:0] o_flag_pin
);
  // pull-ups: low only while pulled
  assign o_phase_pin = ~i_phase_oe;
  assign o_flag_pin  = ~i_flag_oe;
endmodule

//--- test/sps_chk.sv
`timescale 1ns/1ps
module sps_chk
#(
  parameter int unsigned ON_CYCLES = 20
)
(
  input wire logic i_clk, i_rst, i_step, i_direction, i_half_step_select,
  input wire logic i_output_disable, o_phase_a_first_oe, o_phase_a_second_oe,
  input wire logic o_phase_b_first_oe, o_phase_b_second_oe, o_flag_a_oe,
  input wire logic o_flag_b_oe, o_boost_a_oe, o_boost_b_oe
);
  logic       step_q, fall_r, dis_q, mode_q, dir_q;
  logic [3:0] on;
  assign on = {o_phase_a_first_oe, o_phase_a_second_oe, o_phase_b_first_oe, o_phase_b_second_oe};
  always_ff @(posedge i_clk)
  begin
    step_q <= !i_rst & i_step;
    fall_r <= !i_rst & step_q & !i_step;
    dis_q  <= i_rst | i_output_disable;
    mode_q <= i_half_step_select;
    dir_q  <= i_direction;
  end
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  a_hold_state: assert property (!fall_r && !dis_q && !$past(dis_q) |-> $stable(on))
    else $error("phases moved without step");
  a_disable_float: assert property (dis_q |-> on == 4'h0 && !o_flag_a_oe && !o_flag_b_oe)
    else $error("outputs driven while disabled");
  a_full_pair: assert property (fall_r && mode_q && !dis_q |->
    ^on[3:2] && ^on[1:0] && o_flag_a_oe && o_flag_b_oe)
    else $error("full step not in full state");
  a_half_alternate: assert property (fall_r && !mode_q && !dis_q && !$past(dis_q) |->
    $countones(on) != $countones($past(on)))
    else $error("half step did not alternate");
  a_boost_cause: assert property ($rose(o_boost_a_oe) || $rose(o_boost_b_oe) |-> fall_r)
    else $error("boost without step");
  a_no_half_boost: assert property (fall_r && !dis_q && $countones(on) == 1 |->
    !$rose(o_boost_a_oe) && !$rose(o_boost_b_oe))
    else $error("boost entering half state");
  a_boost_len: assert property ($rose(o_boost_b_oe) |-> o_boost_b_oe[*8])
    else $error("boost pulse too short");
  a_fwd_full: assert property (fall_r && mode_q && dir_q && !dis_q && !$past(dis_q) &&
    $past(on) == 4'h9 |-> on == 4'ha && $rose(o_boost_b_oe))
    else $error("forward full step wrong");
  c_fwd: cover property (fall_r && dir_q);
  c_back: cover property (fall_r && !dir_q);
  c_dis: cover property (fall_r && dis_q);
endmodule
bind sps_top sps_chk #(.ON_CYCLES(ON_CYCLES)) u_chk (.*);

//--- test/stepper_phase_sequencer_tb.sv
`timescale 1ns/1ps
module stepper_phase_sequencer_tb;
  localparam int ON = 20;
  logic i_clk = 0, i_rst = 1, i_step = 0, i_direction = 0;
  logic i_half_step_select = 0, i_output_disable = 0;
  wire  [3:0] oe, pin;
  wire  [1:0] foe, fpin;
  wire        ba, bb;
  int failures = 0, n_tests = 0, pos = 0;
  logic [3:0] codes [8] = '{4'ha, 4'he, 4'h6, 4'h7, 4'h5, 4'hd, 4'h9, 4'hb};
  logic [1:0] flags [8] = '{2'h0, 2'h3, 2'h0, 2'h1, 2'h0, 2'h2, 2'h0, 2'h3};
  always #2.5 i_clk = ~i_clk;
  sps_top #(.ON_CYCLES(ON)) u_dut (.i_clk(i_clk), .i_rst(i_rst), .i_step(i_step),
    .i_direction(i_direction), .i_half_step_select(i_half_step_select),
    .i_output_disable(i_output_disable), .o_phase_a_first(), .o_phase_a_first_oe(oe[3]),
    .o_phase_a_second(), .o_phase_a_second_oe(oe[2]), .o_phase_b_first(),
    .o_phase_b_first_oe(oe[1]), .o_phase_b_second(), .o_phase_b_second_oe(oe[0]),
    .o_flag_a(), .o_flag_a_oe(foe[1]), .o_flag_b(), .o_flag_b_oe(foe[0]),
    .o_boost_a(), .o_boost_a_oe(ba), .o_boost_b(), .o_boost_b_oe(bb));
  sps_winding_model u_load (.i_phase_oe(oe), .i_flag_oe(foe), .o_phase_pin(pin),
    .o_flag_pin(fpin));
  task automatic check(string nm, logic [3:0] seen, logic [3:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic print_verdict();
    $display("failures %0d n_tests %0d", failures, n_tests);
    if (failures == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic step(logic dir, logic full, logic dis);
    logic [3:0] c0, c1;
    int d;
    c0 = codes[pos];
    @(negedge i_clk);
    i_step = 1;
    i_direction = dir;
    i_half_step_select = full;
    i_output_disable = dis;
    @(negedge i_clk);
    i_step = 0;
    d = (full && pos % 2 == 0) ? 2 : 1;
    pos = (pos + (dir ? d : 8 - d)) % 8;
    c1 = codes[pos];
    @(negedge i_clk);
    check("phases", pin, dis ? 4'hf : c1);
    check("flags", {2'h0, fpin}, dis ? 4'h3 : {2'h0, flags[pos]});
    @(negedge i_clk);
    check("boost", {2'h0, ba, bb}, (pos % 2) ? 4'h0 :
      {2'h0, |(c0[3:2] & ~c1[3:2]), |(c0[1:0] & ~c1[1:0])});
    repeat (ON) @(negedge i_clk);
    check("boost end", {2'h0, ba, bb}, 4'h0);
    check("held", pin, dis ? 4'hf : c1);
  endtask
  initial
  begin
    #100us;
    failures++;
    print_verdict();
  end
  initial
  begin
    void'($urandom(23952));
    repeat (12) @(negedge i_clk);
    i_rst = 0;
    repeat (2) @(negedge i_clk);
    check("reset", pin, 4'ha);
    check("reset flags", {2'h0, fpin}, 4'h0);
    step(1, 1, 0);
    step(1, 1, 0);
    step(0, 0, 0);
    step(0, 1, 0);
    step(1, 0, 1);
    step(1, 0, 0);
    repeat (40) step(1'($urandom), 1'($urandom), 1'($urandom));
    print_verdict();
  end
endmodule
